// *** verilog/bps_regs.vh ***
// Register map, field layout, reset values and timing for the supervisor
`ifndef BPS_REGS_VH
`define BPS_REGS_VH

// ****
// Timing, grace current and pre-heat disable code
// ****
`define BPS_CLK_HZ 100000000
`define BPS_RESTORE_S 6'd30
`define BPS_NOCOMM_S 6'd10
`define BPS_GRACE_S 6'd10
`define BPS_MIN_LAST_S 6'd59
// Current inputs count in 0.1 A, so 5 A is 50
`define BPS_GRACE_CUR 16'h0032
`define BPS_PREHEAT_OFF 8'h9c

// ****
// Byte offsets
// ****
`define BPS_A_CTRL 12'h000
`define BPS_A_TEMP 12'h004
`define BPS_A_CUR 12'h008
`define BPS_A_CUR2 12'h00c
`define BPS_A_STAGE 12'h010
`define BPS_A_PRE_CV 12'h014
`define BPS_A_MAIN_CV 12'h018
`define BPS_A_BAL_CV 12'h01c
`define BPS_A_STATUS 12'h020
`define BPS_A_EVENTS 12'h024
`define BPS_A_CNT_A 12'h028
`define BPS_A_CNT_B 12'h02c

// ****
// Control bits
// ****
`define BPS_C_CLIM 0
`define BPS_C_OH 1
`define BPS_C_HCR 2
`define BPS_C_RST 3
`define BPS_C_DOC 4
`define BPS_C_GRC 5
`define BPS_C_COC 6
`define BPS_C_NOC 7
`define BPS_C_UVC 8
`define BPS_C_CAN 9

// ****
// Fields
// ****
`define BPS_F_NORM 7:0
`define BPS_F_CHGT 15:8
`define BPS_F_CRIT 23:16
`define BPS_F_MINC 31:24
`define BPS_F_WARN 15:0
`define BPS_F_CRITD 31:16
`define BPS_F_CRITC 15:0
`define BPS_F_MSOC 23:16
`define BPS_F_PRE 9:0
`define BPS_F_MAIN 19:10
`define BPS_F_BAL 29:20
`define BPS_F_CVCUR 15:0
`define BPS_F_CVVOLT 31:16

// ****
// Reset values and error codes
// ****
`define BPS_R_CTRL 10'h000
`define BPS_R_TEMP 32'h9c3c1e19
`define BPS_R_CUR 32'h07d003e8
`define BPS_R_CUR2 24'h0001f4
`define BPS_R_STAGE 30'h07896078
`define BPS_E_NONE 3'h0
`define BPS_E_HEAT 3'h1
`define BPS_E_PRE 3'h2
`define BPS_E_MAIN 3'h3
`define BPS_E_BAL 3'h4

`endif

// *** verilog/bps_top.v ***
// Battery protection supervisor with AHB-Lite register slave
//
// Contract
// R1 - Charging climate: heater below, fan above setpoint
// R2 - Not charging: same control, normal setpoint
// R3 - Over-heat cutoff opens contactor above critical
// R4 - Critical temperature stops charge, flags error
// R5 - Over-heat trip logged and counted
// R6 - Climate control suspended below minimum charge
// R7 - High current reduction drives power reduction
// R8 - Warning current always sounds buzzer
// R9 - High current warning logged and counted
// R10 - Restore window suppresses stage timeout errors 30 s
// R11 - Discharge over-current cutoff opens contactor
// R12 - Discharge over-current trip logged and counted
// R13 - Graceful undervoltage opening delayed to 10 s
// R14 - Charge over-current cutoff opens contactor
// R15 - Charge over-current trip logged and counted
// R16 - Comm loss over 10 s opens contactor
// R17 - Cold start pre-heats before charging
// R18 - Minimum temperature -100 disables pre-heat
// R19 - Relay charger switched by relay, sensed input
// R20 - Bus charger gets per-stage current, voltage
// R21 - Pre-charge timeout raises charging error
// R22 - Main charge timeout raises charging error
// R23 - Balancing timeout raises charging error
// R24 - Second and minute ticks from prescaler
`include "bps_regs.vh"

module bps_top #(
  parameter SEC_CYCLES = `BPS_CLK_HZ
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Pack measurements
  input wire signed [7:0] avg_temp,
  input wire signed [7:0] max_temp,
  input wire signed [7:0] min_temp,
  input wire [15:0] dis_cur,
  input wire [15:0] chg_cur,
  input wire [7:0] soc,
  input wire cell_comm_ok,
  input wire undervolt,
  // Charger side
  input wire charger_sense_input_function,
  input wire bus_charger_present,
  input wire cells_precharged,
  input wire cells_full,
  input wire cells_balanced,
  // Control outputs
  output reg heater_output_function,
  output reg fan_output_function,
  output reg contactor_cutoff_function,
  output reg power_reduction_function,
  output reg buzzer_output_function,
  output reg charger_relay_function,
  // Bus charger command
  output reg [15:0] chg_cur_cmd,
  output reg [15:0] chg_volt_cmd,
  output reg chg_msg_stb,
  // Charge status
  output reg charge_error,
  output reg [2:0] error_code
);

  localparam S_IDLE = 3'h0;
  localparam S_HEAT = 3'h1;
  localparam S_PRE = 3'h2;
  localparam S_MAIN = 3'h3;
  localparam S_BAL = 3'h4;
  localparam S_DONE = 3'h5;
  localparam S_ERR = 3'h6;

  // ****
  // Register bus
  // ****
  reg [9:0] ctrl_reg;
  reg [31:0] temp_reg;
  reg [31:0] cur_reg;
  reg [23:0] cur2_reg;
  reg [29:0] stage_reg;
  reg [31:0] pre_cv_reg;
  reg [31:0] main_cv_reg;
  reg [31:0] bal_cv_reg;
  reg [3:0] evt_reg;
  reg [15:0] cnt_oh_reg;
  reg [15:0] cnt_warn_reg;
  reg [15:0] cnt_doc_reg;
  reg [15:0] cnt_coc_reg;
  reg [11:0] addr_reg;
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [31:0] rd_mux;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] code_reg;
  reg [2:0] code_next;
  reg [5:0] lost_s_reg;
  reg [5:0] grace_s_reg;
  reg [5:0] win_reg;

  wire acc = hsel & htrans[1] & hready;
  wire wr_ev = wr_pend_reg & (addr_reg == `BPS_A_EVENTS);
  wire [3:0] evt_clr = wr_ev ? hwdata[3:0] : 4'h0;

  // Writes finish without wait; reads take one wait state so a read
  // right after a write sees the new value
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 12'h000;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= acc & hwrite;
      rd_pend_reg <= acc & ~hwrite;
      if (acc) begin
        addr_reg <= haddr[11:0];
      end
      if (acc & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout <= 1'b1;
        hrdata <= rd_mux;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `BPS_R_CTRL;
      temp_reg <= `BPS_R_TEMP;
      cur_reg <= `BPS_R_CUR;
      cur2_reg <= `BPS_R_CUR2;
      stage_reg <= `BPS_R_STAGE;
      pre_cv_reg <= 32'h00000000;
      main_cv_reg <= 32'h00000000;
      bal_cv_reg <= 32'h00000000;
    end else if (wr_pend_reg) begin
      if (addr_reg == `BPS_A_CTRL) begin
        ctrl_reg <= hwdata[9:0];
      end else if (addr_reg == `BPS_A_TEMP) begin
        temp_reg <= hwdata;
      end else if (addr_reg == `BPS_A_CUR) begin
        cur_reg <= hwdata;
      end else if (addr_reg == `BPS_A_CUR2) begin
        cur2_reg <= hwdata[23:0];
      end else if (addr_reg == `BPS_A_STAGE) begin
        stage_reg <= hwdata[29:0];
      end else if (addr_reg == `BPS_A_PRE_CV) begin
        pre_cv_reg <= hwdata;
      end else if (addr_reg == `BPS_A_MAIN_CV) begin
        main_cv_reg <= hwdata;
      end else if (addr_reg == `BPS_A_BAL_CV) begin
        bal_cv_reg <= hwdata;
      end
    end
  end

  // ****
  // Thresholds
  // ****
  wire signed [7:0] norm_t = temp_reg[`BPS_F_NORM];
  wire signed [7:0] chg_t = temp_reg[`BPS_F_CHGT];
  wire signed [7:0] crit_t = temp_reg[`BPS_F_CRIT];
  wire signed [7:0] minc_t = temp_reg[`BPS_F_MINC];
  wire [15:0] warn_i = cur_reg[`BPS_F_WARN];
  wire [15:0] critd_i = cur_reg[`BPS_F_CRITD];
  wire [15:0] critc_i = cur2_reg[`BPS_F_CRITC];
  wire [7:0] min_soc = cur2_reg[`BPS_F_MSOC];

  // ****
  // Timebase
  // ****
  reg [31:0] pre_cnt_reg;
  reg [5:0] sec_reg;
  wire sec_tick = (pre_cnt_reg == SEC_CYCLES - 1);
  wire min_tick = sec_tick & (sec_reg == `BPS_MIN_LAST_S);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 32'h00000000;
      sec_reg <= 6'h00;
    end else begin
      pre_cnt_reg <= sec_tick ? 32'h0 : pre_cnt_reg + 32'h1; // R24
      if (min_tick) begin
        sec_reg <= 6'h00; // R24
      end else if (sec_tick) begin
        sec_reg <= sec_reg + 6'h01;
      end
    end
  end

  // ****
  // Protection
  // ****
  wire oh_trip = ctrl_reg[`BPS_C_OH] & (max_temp > crit_t); // R3
  wire warn_hit = dis_cur > warn_i; // R8
  wire doc_trip = ctrl_reg[`BPS_C_DOC] & (dis_cur > critd_i); // R11
  wire coc_trip = ctrl_reg[`BPS_C_COC] & (chg_cur > critc_i); // R14
  wire crit_reach = max_temp >= crit_t; // R4
  wire comm_lost = lost_s_reg > `BPS_NOCOMM_S; // R16
  wire heavy = dis_cur > `BPS_GRACE_CUR;
  wire graceful = ctrl_reg[`BPS_C_GRC] & heavy;
  wire grace_over = grace_s_reg >= `BPS_GRACE_S;
  wire uv_cut = ctrl_reg[`BPS_C_UVC] & undervolt &
                (~graceful | grace_over); // R13
  wire cut_now = oh_trip | doc_trip | coc_trip | uv_cut |
                 (ctrl_reg[`BPS_C_NOC] & comm_lost); // R16

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_s_reg <= 6'h00;
      grace_s_reg <= 6'h00;
    end else begin
      if (cell_comm_ok) begin
        lost_s_reg <= 6'h00;
      end else if (sec_tick & (lost_s_reg != 6'h3f)) begin
        lost_s_reg <= lost_s_reg + 6'h01; // R16
      end
      if (!undervolt) begin
        grace_s_reg <= 6'h00;
      end else if (sec_tick & (grace_s_reg != 6'h3f)) begin
        grace_s_reg <= grace_s_reg + 6'h01; // R13
      end
    end
  end

  // ****
  // Event log and statistics
  // ****
  reg [3:0] trip_q_reg;
  wire [3:0] trips = {coc_trip, doc_trip, warn_hit, oh_trip};
  wire [3:0] rises = trips & ~trip_q_reg;

  function [15:0] sat_inc;
    input [15:0] v;
    begin
      sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    end
  endfunction

  // A trip landing in the same cycle as its clear stays set
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_q_reg <= 4'h0;
      evt_reg <= 4'h0;
      cnt_oh_reg <= 16'h0000;
      cnt_warn_reg <= 16'h0000;
      cnt_doc_reg <= 16'h0000;
      cnt_coc_reg <= 16'h0000;
    end else begin
      trip_q_reg <= trips;
      evt_reg <= (evt_reg & ~evt_clr) | rises; // R5 R9 R12 R15
      if (rises[0]) begin
        cnt_oh_reg <= sat_inc(cnt_oh_reg); // R5
      end
      if (rises[1]) begin
        cnt_warn_reg <= sat_inc(cnt_warn_reg); // R9
      end
      if (rises[2]) begin
        cnt_doc_reg <= sat_inc(cnt_doc_reg); // R12
      end
      if (rises[3]) begin
        cnt_coc_reg <= sat_inc(cnt_coc_reg); // R15
      end
    end
  end

  // ****
  // Charge sequencing
  // ****
  wire bus_chg = ctrl_reg[`BPS_C_CAN];
  wire conn = bus_chg ? bus_charger_present :
              charger_sense_input_function; // R19
  wire restore = win_reg != 6'h00;
  wire heat_off = temp_reg[`BPS_F_MINC] == `BPS_PREHEAT_OFF; // R18
  wire cold = ~heat_off & (min_temp < minc_t); // R17 R18
  reg conn_q_reg;
  reg [9:0] stage_min_reg;
  wire charging = (state_reg == S_PRE) | (state_reg == S_MAIN) |
                  (state_reg == S_BAL);

  function [9:0] stage_limit;
    input [2:0] st;
    input [29:0] lim;
    begin
      if (st == S_PRE) begin
        stage_limit = lim[`BPS_F_PRE];
      end else if (st == S_MAIN) begin
        stage_limit = lim[`BPS_F_MAIN];
      end else begin
        stage_limit = lim[`BPS_F_BAL];
      end
    end
  endfunction

  wire timeout = ~restore &
                 (stage_min_reg >= stage_limit(state_reg, stage_reg)); // R10

  always @* begin
    state_next = state_reg;
    code_next = code_reg;
    case (state_reg)
      S_IDLE: begin
        if (conn) begin
          code_next = `BPS_E_NONE;
          state_next = cold ? S_HEAT : S_PRE; // R17
        end
      end
      S_HEAT: begin
        if (!cold) begin
          state_next = S_PRE; // R17
        end
      end
      S_PRE: begin
        if (cells_precharged) begin
          state_next = S_MAIN;
        end else if (timeout) begin
          state_next = S_ERR; // R21
          code_next = `BPS_E_PRE;
        end
      end
      S_MAIN: begin
        if (cells_full) begin
          state_next = S_BAL;
        end else if (timeout) begin
          state_next = S_ERR; // R22
          code_next = `BPS_E_MAIN;
        end
      end
      S_BAL: begin
        if (cells_balanced) begin
          state_next = S_DONE;
        end else if (timeout) begin
          state_next = S_ERR; // R23
          code_next = `BPS_E_BAL;
        end
      end
      default: begin
        state_next = state_reg;
      end
    endcase
    if (conn & crit_reach & (state_reg != S_ERR)) begin
      state_next = S_ERR; // R4
      code_next = `BPS_E_HEAT;
    end
    if (!conn) begin
      state_next = S_IDLE;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      code_reg <= `BPS_E_NONE;
      stage_min_reg <= 10'h000;
      conn_q_reg <= 1'b0;
      win_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      conn_q_reg <= conn;
      if (state_next != state_reg) begin
        stage_min_reg <= 10'h000;
      end else if (min_tick & (stage_min_reg != 10'h3ff)) begin
        stage_min_reg <= stage_min_reg + 10'h001; // R24
      end
      // Window opens only on a fresh connection of a depleted pack
      if (!conn) begin
        win_reg <= 6'h00;
      end else if (~conn_q_reg & ctrl_reg[`BPS_C_RST] &
                   (~cell_comm_ok | undervolt)) begin
        win_reg <= `BPS_RESTORE_S; // R10
      end else if (sec_tick & restore) begin
        win_reg <= win_reg - 6'h01; // R10
      end
    end
  end

  // ****
  // Outputs
  // ****
  wire signed [7:0] setp = charging ? chg_t : norm_t; // R1 R2
  // Climate control stops on low charge to avoid deep discharge
  wire clim = ctrl_reg[`BPS_C_CLIM] & (soc >= min_soc); // R6

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      heater_output_function <= 1'b0;
      fan_output_function <= 1'b0;
      contactor_cutoff_function <= 1'b0;
      power_reduction_function <= 1'b0;
      buzzer_output_function <= 1'b0;
      charger_relay_function <= 1'b0;
      chg_cur_cmd <= 16'h0000;
      chg_volt_cmd <= 16'h0000;
      chg_msg_stb <= 1'b0;
      charge_error <= 1'b0;
      error_code <= `BPS_E_NONE;
    end else begin
      heater_output_function <= (clim & (avg_temp < setp)) |
                                (state_reg == S_HEAT); // R1 R2 R17
      fan_output_function <= clim & (avg_temp > setp); // R1 R2
      contactor_cutoff_function <= cut_now; // R3 R11 R14
      power_reduction_function <= ctrl_reg[`BPS_C_HCR] &
                                  warn_hit; // R7
      buzzer_output_function <= warn_hit; // R8
      charger_relay_function <= charging & ~bus_chg; // R19
      chg_msg_stb <= bus_chg & charging & sec_tick; // R20
      charge_error <= state_reg == S_ERR; // R4
      error_code <= code_reg;
      if (bus_chg & (state_reg == S_PRE)) begin
        chg_cur_cmd <= pre_cv_reg[`BPS_F_CVCUR]; // R20
        chg_volt_cmd <= pre_cv_reg[`BPS_F_CVVOLT];
      end else if (bus_chg & (state_reg == S_MAIN)) begin
        chg_cur_cmd <= main_cv_reg[`BPS_F_CVCUR]; // R20
        chg_volt_cmd <= main_cv_reg[`BPS_F_CVVOLT];
      end else if (bus_chg & (state_reg == S_BAL)) begin
        chg_cur_cmd <= bal_cv_reg[`BPS_F_CVCUR]; // R20
        chg_volt_cmd <= bal_cv_reg[`BPS_F_CVVOLT];
      end else begin
        chg_cur_cmd <= 16'h0000;
        chg_volt_cmd <= 16'h0000;
      end
    end
  end

  // ****
  // Read decode
  // ****
  always @* begin
    rd_mux = 32'h00000000;
    if (addr_reg == `BPS_A_CTRL) begin
      rd_mux = {22'h000000, ctrl_reg};
    end else if (addr_reg == `BPS_A_TEMP) begin
      rd_mux = temp_reg;
    end else if (addr_reg == `BPS_A_CUR) begin
      rd_mux = cur_reg;
    end else if (addr_reg == `BPS_A_CUR2) begin
      rd_mux = {8'h00, cur2_reg};
    end else if (addr_reg == `BPS_A_STAGE) begin
      rd_mux = {2'h0, stage_reg};
    end else if (addr_reg == `BPS_A_PRE_CV) begin
      rd_mux = pre_cv_reg;
    end else if (addr_reg == `BPS_A_MAIN_CV) begin
      rd_mux = main_cv_reg;
    end else if (addr_reg == `BPS_A_BAL_CV) begin
      rd_mux = bal_cv_reg;
    end else if (addr_reg == `BPS_A_STATUS) begin
      rd_mux = {18'h00000, restore, comm_lost, state_reg, code_reg,
                charger_relay_function, buzzer_output_function,
                power_reduction_function, contactor_cutoff_function,
                fan_output_function, heater_output_function};
    end else if (addr_reg == `BPS_A_EVENTS) begin
      rd_mux = {28'h0000000, evt_reg};
    end else if (addr_reg == `BPS_A_CNT_A) begin
      rd_mux = {cnt_warn_reg, cnt_oh_reg};
    end else if (addr_reg == `BPS_A_CNT_B) begin
      rd_mux = {cnt_coc_reg, cnt_doc_reg};
    end
  end

endmodule // bps_top

// *** sim/bps_props.sv ***
// Port-level checks for the battery protection supervisor
module bps_props #(
  parameter SEC_CYCLES = 20
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // Measurements and charger
  input wire signed [7:0] max_temp,
  input wire [15:0] dis_cur,
  input wire [15:0] chg_cur,
  input wire [7:0] soc,
  input wire charger_sense_input_function,
  input wire bus_charger_present,
  // Outputs
  input wire heater_output_function,
  input wire fan_output_function,
  input wire contactor_cutoff_function,
  input wire power_reduction_function,
  input wire buzzer_output_function,
  input wire charger_relay_function,
  input wire chg_msg_stb,
  input wire charge_error,
  input wire [2:0] error_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Shadow of the threshold registers
  // ****
  logic [31:0] ctrl_reg, temp_reg, cur_reg, cur2_reg;
  logic wr_reg;
  logic [1:0] idx_reg;
  wire signed [7:0] crit_t = temp_reg[23:16];
  wire hot_c = max_temp >= crit_t;
  wire warn_c = dis_cur > cur_reg[15:0];
  wire pwr_c = ctrl_reg[2] && warn_c;
  wire fan_c = ctrl_reg[0] && soc >= cur2_reg[23:16];
  wire stb_c = ctrl_reg[9] && bus_charger_present;
  wire trip_c = ctrl_reg[1] && max_temp > crit_t ||
    ctrl_reg[4] && dis_cur > cur_reg[31:16] ||
    ctrl_reg[6] && chg_cur > cur2_reg[15:0];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 32'h0;
      temp_reg <= 32'h9c3c1e19;
      cur_reg <= 32'h07d003e8;
      cur2_reg <= 32'h000001f4;
      wr_reg <= 1'b0;
      idx_reg <= 2'h0;
    end else if (hready) begin
      wr_reg <= hsel && htrans[1] && hwrite && haddr[11:4] == 8'h00;
      idx_reg <= haddr[3:2];
      if (wr_reg) begin
        case (idx_reg)
          2'h0: ctrl_reg <= hwdata;
          2'h1: temp_reg <= hwdata;
          2'h2: cur_reg <= hwdata;
          default: cur2_reg <= hwdata;
        endcase
      end
    end
  end
  // ****
  // Assertions
  // ****
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  read_wait_a:
    assert property (hsel && htrans[1] && hready && !hwrite
      |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  okay_resp_a:
    assert property (!hresp) else $error("error response");
  buzz_warn_a:
    assert property (buzzer_output_function == $past(warn_c))
    else $error("buzzer wrong");
  pwr_red_a:
    assert property (power_reduction_function == $past(pwr_c))
    else $error("power reduction wrong");
  trip_cut_a:
    assert property ($past(trip_c) |-> contactor_cutoff_function)
    else $error("cutoff missing");
  fan_soc_a:
    assert property (fan_output_function |-> $past(fan_c))
    else $error("fan while suspended");
  heat_fan_a:
    assert property (!(heater_output_function && fan_output_function))
    else $error("heater and fan together");
  err_code_a:
    assert property (charge_error |-> error_code != 3'h0)
    else $error("error without code");
  hot_err_a:
    assert property ($rose(charge_error) && error_code == 3'h1
      |-> $past(hot_c) || $past(hot_c, 2)) else $error("heat error cause");
  relay_sense_a:
    assert property ($rose(charger_relay_function)
      |-> $past(charger_sense_input_function)) else $error("relay no mains");
  bus_stb_a:
    assert property (chg_msg_stb |-> $past(stb_c))
    else $error("message without bus charger");
endmodule // bps_props

// *** sim/bps_partner.sv ***
// Charger and cell module model facing the supervisor
module bps_partner (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Bench commands
  input wire plug,
  input wire bus_mode,
  input wire slow,
  // From the supervisor
  input wire charger_relay_function,
  input wire [15:0] chg_cur_cmd,
  // To the supervisor
  output wire charger_sense_input_function,
  output wire bus_charger_present,
  output wire cells_precharged,
  output wire cells_full,
  output wire cells_balanced
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] t_reg;
  // Cells only progress while current is really delivered
  wire on = charger_relay_function || chg_cur_cmd != 16'h0000;
  // Mains sense exists on the relay type only
  assign charger_sense_input_function = plug && !bus_mode;
  assign bus_charger_present = plug && bus_mode;
  // A slow pack stalls and never reaches a stage voltage
  assign cells_precharged = !slow && t_reg >= 10'd200;
  assign cells_full = !slow && t_reg >= 10'd400;
  assign cells_balanced = !slow && t_reg >= 10'd600;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      t_reg <= 10'h000;
    else if (!plug)
      t_reg <= 10'h000;
    else if (on && t_reg != 10'h3ff)
      t_reg <= t_reg + 10'h001;
  end
endmodule // bps_partner

// *** sim/bps_top_tb.sv ***
// Self-checking bench for the battery protection supervisor
module bps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic signed [7:0] avg_temp = 8'sd20, max_temp = 8'sd20;
  logic signed [7:0] min_temp = 8'sd20;
  logic [15:0] dis_cur = 16'h0, chg_cur = 16'h0;
  logic [7:0] soc = 8'h32;
  logic cell_comm_ok = 1'b1, undervolt = 1'b0;
  logic plug = 1'b0, bus_mode = 1'b0, slow = 1'b0;
  wire hready, hreadyout, hresp;
  wire [31:0] hrdata;
  wire heater_output_function, fan_output_function;
  wire contactor_cutoff_function, power_reduction_function;
  wire buzzer_output_function, charger_relay_function;
  wire [15:0] chg_cur_cmd, chg_volt_cmd;
  wire chg_msg_stb, charge_error;
  wire [2:0] error_code;
  wire charger_sense_input_function, bus_charger_present;
  wire cells_precharged, cells_full, cells_balanced;
  wire [4:0] outs = {heater_output_function, fan_output_function,
    contactor_cutoff_function, power_reduction_function,
    buzzer_output_function};
  logic [31:0] dflt [5] = '{32'h0, 32'h9c3c1e19, 32'h07d003e8,
    32'h000001f4, 32'h07896078};
  logic [31:0] r, b;
  logic [9:0] c;
  int err_count = 0, checks_done = 0;
  int i, k, a, m, d, g, s;
  integer seed;
  assign hready = hreadyout;
  always #5 core_clk = ~core_clk;
  bps_top #(.SEC_CYCLES(SEC)) u_bps_top (.*);
  bps_partner u_bps_partner (.*);
  // ****
  // Tasks
  // ****
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    err_count++;
    stop_test;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic note(input string t);
    $display("test %s finished", t);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [11:0] ad,
    input logic [31:0] dt, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, ad};
    do @(posedge core_clk); while (!hready && ++n < 99);
    htrans <= 2'h0;
    hwdata <= dt;
    do @(posedge core_clk); while (!hready && ++n < 99);
    rd = hrdata;
    if (n >= 99)
      timeout;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    logic [31:0] q;
    bus(1'b1, ad, dt, q);
  endtask
  task automatic wait_st(input logic [2:0] st);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, 12'h020, 32'h0, q);
      n++;
    end while (q[11:9] !== st && n < 999);
    if (n >= 999)
      timeout;
    cyc(2);
  endtask
  function automatic logic [4:0] exp_o(input logic [9:0] cb,
    input int at, mt, dc, gc, sc);
    logic on;
    on = cb[0] && sc >= 40;
    exp_o = {on && at < 25, on && at > 25, cb[1] && mt > 60 ||
      cb[4] && dc > 2000 || cb[6] && gc > 500, cb[2] && dc > 1000,
      dc > 1000};
  endfunction
  function automatic logic [31:0] cv(input int n);
    cv = 32'h0d200080 + 32'(n) * 32'h00100010;
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 32'h81260937;
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    for (i = 0; i < 5; i++) begin
      bus(1'b0, 12'(4 * i), 32'h0, r);
      chk(r, dflt[i]);
    end
    wr(12'h0f0, 32'h5);
    bus(1'b0, 12'h0f0, 32'h0, r);
    chk(r, 32'h0);
    note("registers");
    wr(12'h00c, 32'h002801f4);
    for (i = 0; i < 40; i++) begin
      c = 10'($random(seed)) & 10'h0d7;
      a = $unsigned($random(seed)) % 51;
      m = 40 + $unsigned($random(seed)) % 41;
      d = $unsigned($random(seed)) % 3001;
      g = $unsigned($random(seed)) % 801;
      s = $unsigned($random(seed)) % 101;
      if (i == 0) begin
        d = 1000;
        m = 60;
        g = 501;
        s = 40;
      end
      wr(12'h000, {22'h0, c});
      avg_temp <= 8'(a);
      max_temp <= 8'(m);
      dis_cur <= 16'(d);
      chg_cur <= 16'(g);
      soc <= 8'(s);
      cyc(3);
      chk(32'(outs), 32'(exp_o(c, a, m, d, g, s)));
    end
    note("thresholds");
    max_temp <= 8'sd20;
    dis_cur <= 16'h0;
    chg_cur <= 16'h0;
    wr(12'h000, 32'h052);
    wr(12'h024, 32'hf);
    for (k = 0; k < 4; k++) begin
      bus(1'b0, 12'h028 + 12'(k / 2 * 4), 32'h0, b);
      max_temp <= k == 0 ? 8'sd70 : 8'sd20;
      dis_cur <= k == 1 ? 16'd1500 : k == 2 ? 16'd2500 : 16'd0;
      chg_cur <= k == 3 ? 16'd600 : 16'd0;
      cyc(3);
      max_temp <= 8'sd20;
      dis_cur <= 16'h0;
      chg_cur <= 16'h0;
      cyc(3);
      bus(1'b0, 12'h028 + 12'(k / 2 * 4), 32'h0, r);
      chk(r >> (k % 2 * 16) & 32'hffff,
        (b >> (k % 2 * 16) & 32'hffff) + 1);
      bus(1'b0, 12'h024, 32'h0, r);
      chk(32'(r[k]), 32'h1);
    end
    note("events");
    wr(12'h000, 32'h080);
    cell_comm_ok <= 1'b0;
    cyc(9 * SEC);
    chk(32'(contactor_cutoff_function), 32'h0);
    cyc(4 * SEC);
    chk(32'(contactor_cutoff_function), 32'h1);
    cell_comm_ok <= 1'b1;
    wr(12'h000, 32'h120);
    dis_cur <= 16'd100;
    undervolt <= 1'b1;
    cyc(8 * SEC);
    chk(32'(contactor_cutoff_function), 32'h0);
    cyc(4 * SEC);
    chk(32'(contactor_cutoff_function), 32'h1);
    undervolt <= 1'b0;
    dis_cur <= 16'h0;
    note("cutoff");
    wr(12'h000, 32'h0);
    wr(12'h010, 32'h00100401);
    wr(12'h004, 32'h053c1e19);
    min_temp <= 8'sd0;
    slow <= 1'b1;
    plug <= 1'b1;
    wait_st(3'h1);
    chk({heater_output_function, charger_relay_function}, 32'h2);
    min_temp <= 8'sd10;
    wait_st(3'h2);
    chk(32'(charger_relay_function), 32'h1);
    wait_st(3'h6);
    chk({charger_relay_function, error_code}, 32'h2);
    plug <= 1'b0;
    wait_st(3'h0);
    note("relay charger");
    wr(12'h000, 32'h200);
    wr(12'h004, 32'h9c3c1e19);
    wr(12'h010, 32'h07896078);
    for (k = 0; k < 3; k++)
      wr(12'h014 + 12'(4 * k), cv(k));
    min_temp <= -8'sd110;
    slow <= 1'b0;
    bus_mode <= 1'b1;
    plug <= 1'b1;
    for (k = 0; k < 3; k++) begin
      wait_st(3'(k + 2));
      chk({chg_volt_cmd, chg_cur_cmd}, cv(k));
    end
    wait_st(3'h5);
    max_temp <= 8'sd65;
    wait_st(3'h6);
    chk(32'(error_code), 32'h1);
    plug <= 1'b0;
    max_temp <= 8'sd20;
    wait_st(3'h0);
    note("bus charger");
    stop_test;
  end
endmodule // bps_top_tb

bind bps_top bps_props #(.SEC_CYCLES(SEC_CYCLES)) u_bps_props (.*);
